// *** design/sda_defines.vh ***
`ifndef SDA_DEFINES_VH
`define SDA_DEFINES_VH

// abort reason codes carried in bytes four to seven of an abort reply
`define SDA_AB_TOGGLE 32'h05030000
`define SDA_AB_CMD 32'h05040001
`define SDA_AB_RDONLY 32'h06010002
`define SDA_AB_NO_OBJ 32'h06020000
`define SDA_AB_NO_MAP 32'h06040041
`define SDA_AB_MAP_LEN 32'h06040042
`define SDA_AB_LONG 32'h06070012
`define SDA_AB_SHORT 32'h06070013
`define SDA_AB_NO_SUB 32'h06090011
`define SDA_AB_HIGH 32'h06090031
`define SDA_AB_LOW 32'h06090032
`define SDA_AB_GENERAL 32'h08000000
`define SDA_AB_STATE 32'h08000022

// command byte: client command specifier in bits 7:5
`define SDA_CCS_DL_INIT 3'h1
`define SDA_CCS_UL_INIT 3'h2
`define SDA_CCS_UL_SEG 3'h3
`define SDA_CCS_ABORT 3'h4
// command byte of an abort reply
`define SDA_ABORT_BYTE 8'h80

// network states
`define SDA_NMT_PREOP 2'h0
`define SDA_NMT_OPER 2'h1
`define SDA_NMT_STOP 2'h2

// pdo parameter index groups (upper byte) and limits
`define SDA_PDO_RXCOM 8'h14
`define SDA_PDO_RXMAP 8'h16
`define SDA_PDO_TXCOM 8'h18
`define SDA_PDO_TXMAP 8'h1a
`define SDA_PDO_MAX_BYTES 4'h8
`define SDA_PDO_SLOTS 16

// reply buffer
`define SDA_FIFO_WIDTH 64
`define SDA_FIFO_DEPTH 16
`define SDA_FIFO_AW 4

`endif

// *** design/sda_fifo.v ***
`default_nettype none

// synchronous fifo with valid/ready on both sides
module sda_fifo #(
   parameter WIDTH = 64,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire mclk,
   input wire rst,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);

   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_r;
   reg [AW-1:0] rd_ptr_r;
   reg [AW:0] cnt_r;
   wire push;
   wire pop;

   // full and empty come straight from the fill count
   assign in_ready = (cnt_r != DEPTH[AW:0]);
   assign out_valid = (cnt_r != {(AW+1){1'b0}});
   assign out_data = mem_r[rd_ptr_r];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // storage array, written only
   always @(posedge mclk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   // pointers and count
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         if (push & ~pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop & ~push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// *** design/sda_checker.v ***
`include "sda_defines.vh"
`default_nettype none

module sda_checker (
   input wire mclk,
   input wire rst,
   // sdo request frame from the bus, byte 0 in bits 7:0
   input wire req_valid,
   output wire req_ready,
   input wire [63:0] req_data,
   // network state
   input wire [1:0] nmt_state,
   // dictionary lookup, answered in the same cycle
   output wire [15:0] od_index,
   output wire [7:0] od_sub,
   input wire od_idx_ok,
   input wire od_sub_ok,
   input wire od_ro,
   input wire od_seg,
   input wire od_mappable,
   input wire [2:0] od_size,
   input wire [31:0] od_min,
   input wire [31:0] od_max,
   // failure reported by the dictionary engine
   input wire gen_err_valid,
   output wire gen_err_ready,
   // end of a segmented upload, from the dictionary engine
   input wire seg_last,
   // checked request handed on to the dictionary engine
   output wire acc_valid,
   output wire [63:0] acc_data,
   // abort replies toward the bus
   output wire rsp_valid,
   input wire rsp_ready,
   output wire [63:0] rsp_data,
   // pdo framework and segmented upload status
   output wire pdo_active,
   output wire [63:0] pdo_len,
   output wire seg_busy
);

   localparam ST_IDLE = 2'h0;
   localparam ST_LOOK = 2'h1;
   localparam ST_MAP = 2'h2;
   localparam ST_PUSH = 2'h3;

   // true for the pdo communication and mapping parameter indices
   function is_pdo_par;
      input [15:0] idx;
      begin
         is_pdo_par = ((idx[15:8] == `SDA_PDO_RXCOM) ||
                       (idx[15:8] == `SDA_PDO_RXMAP) ||
                       (idx[15:8] == `SDA_PDO_TXCOM) ||
                       (idx[15:8] == `SDA_PDO_TXMAP)) &&
                      (idx[7:3] == 5'h00);
      end
   endfunction

   // true for the pdo mapping (content) indices only
   function is_pdo_map;
      input [15:0] idx;
      begin
         is_pdo_map = ((idx[15:8] == `SDA_PDO_RXMAP) ||
                       (idx[15:8] == `SDA_PDO_TXMAP)) &&
                      (idx[7:3] == 5'h00);
      end
   endfunction

   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [63:0] frm_r;
   reg [31:0] code_r;
   reg [31:0] code_nxt;
   reg toggle_r;
   reg seg_r;
   reg acc_valid_r;
   reg [63:0] acc_data_r;
   reg [3:0] map_len_r [0:`SDA_PDO_SLOTS-1];
   reg fail_nxt;
   reg ok_nxt;
   reg upd_nxt;
   reg [3:0] len_nxt;

   wire [7:0] cmd;
   wire [2:0] ccs;
   wire [15:0] idx;
   wire [7:0] sub;
   wire [31:0] val;
   wire [2:0] dl_bytes;
   wire [31:0] dl_mask;
   wire [31:0] dl_val;
   wire [3:0] slot;
   wire [3:0] cur_len;
   wire [4:0] add_len;
   wire fifo_ready;
   wire take_req;
   wire take_err;

   // request fields
   assign cmd = frm_r[7:0];
   assign ccs = cmd[7:5];
   assign idx = frm_r[23:8];
   assign sub = frm_r[31:24];
   assign val = frm_r[63:32];

   // expedited download: n in bits 3:2 counts unused bytes
   assign dl_bytes = 3'h4 - {1'b0, cmd[3:2]};
   assign dl_mask = 32'hffffffff >> {cmd[3:2], 3'h0};
   assign dl_val = val & dl_mask;

   // rx mappings use slots 0..7, tx mappings slots 8..15
   assign slot = {idx[11], idx[2:0]};
   assign cur_len = map_len_r[slot];
   // mapping entry holds <index><subindex><bit length>; bytes added
   assign add_len = {1'b0, cur_len} + {1'b0, val[6:3]};

   // lookup points at the mapped object while checking a mapping entry
   assign od_index = (state_r == ST_MAP) ? val[31:16] : idx;
   assign od_sub = (state_r == ST_MAP) ? val[15:8] : sub;

   // handshakes: one request at a time, engine failures first
   assign take_err = (state_r == ST_IDLE) & gen_err_valid;
   assign take_req = (state_r == ST_IDLE) & ~gen_err_valid & req_valid;
   assign gen_err_ready = (state_r == ST_IDLE);
   assign req_ready = (state_r == ST_IDLE) & ~gen_err_valid;

   assign acc_valid = acc_valid_r;
   assign acc_data = acc_data_r;
   assign seg_busy = seg_r;
   assign pdo_active = (nmt_state == `SDA_NMT_OPER);

   // flatten mapped lengths, four bits per mapping
   genvar g;
   generate
      for (g = 0; g < `SDA_PDO_SLOTS; g = g + 1) begin : g_len
         assign pdo_len[g*4 +: 4] = map_len_r[g];
      end
   endgenerate

   // checks on the captured request; first failure found wins
   always @* begin
      code_nxt = `SDA_AB_GENERAL;
      fail_nxt = 1'b0;
      ok_nxt = 1'b0;
      upd_nxt = 1'b0;
      len_nxt = cur_len;
      if (state_r == ST_LOOK) begin
         if (ccs == `SDA_CCS_UL_SEG) begin
            if (cmd[3:0] != 4'h0) begin
               fail_nxt = 1'b1;
               code_nxt = `SDA_AB_CMD;
            end else if (!seg_r) begin
               fail_nxt = 1'b1;
               code_nxt = `SDA_AB_GENERAL;
            end else if (cmd[4] != toggle_r) begin
               fail_nxt = 1'b1;
               code_nxt = `SDA_AB_TOGGLE;
            end else begin
               ok_nxt = 1'b1;
            end
         end else if (!((ccs == `SDA_CCS_UL_INIT && cmd[4:0] == 5'h00) ||
                        (ccs == `SDA_CCS_DL_INIT && cmd[4] == 1'b0 &&
                         cmd[1:0] == 2'h3))) begin
            fail_nxt = 1'b1;
            code_nxt = `SDA_AB_CMD;
         end else if (!od_idx_ok) begin
            fail_nxt = 1'b1;
            code_nxt = `SDA_AB_NO_OBJ;
         end else if (!od_sub_ok) begin
            fail_nxt = 1'b1;
            code_nxt = `SDA_AB_NO_SUB;
         end else if (ccs == `SDA_CCS_UL_INIT) begin
            ok_nxt = 1'b1;
         end else if (od_ro) begin
            fail_nxt = 1'b1;
            code_nxt = `SDA_AB_RDONLY;
         end else if (is_pdo_par(idx) &&
                      nmt_state == `SDA_NMT_OPER) begin
            fail_nxt = 1'b1;
            code_nxt = `SDA_AB_STATE;
         end else if (dl_bytes > od_size) begin
            fail_nxt = 1'b1;
            code_nxt = `SDA_AB_LONG;
         end else if (dl_bytes < od_size) begin
            fail_nxt = 1'b1;
            code_nxt = `SDA_AB_SHORT;
         end else if (dl_val > od_max) begin
            fail_nxt = 1'b1;
            code_nxt = `SDA_AB_HIGH;
         end else if (dl_val < od_min) begin
            fail_nxt = 1'b1;
            code_nxt = `SDA_AB_LOW;
         end else if (is_pdo_map(idx) && sub == 8'h00) begin
            // clearing the object count empties the mapping
            ok_nxt = 1'b1;
            if (dl_val == 32'h00000000) begin
               upd_nxt = 1'b1;
               len_nxt = 4'h0;
            end
         end else if (!is_pdo_map(idx)) begin
            ok_nxt = 1'b1;
         end
      end else if (state_r == ST_MAP) begin
         // the lookup now answers for the object being mapped
         if (!od_idx_ok || !od_sub_ok || !od_mappable) begin
            fail_nxt = 1'b1;
            code_nxt = `SDA_AB_NO_MAP;
         end else if (val[2:0] != 3'h0) begin
            fail_nxt = 1'b1;
            code_nxt = `SDA_AB_GENERAL;
         end else if (add_len > {1'b0, `SDA_PDO_MAX_BYTES}) begin
            fail_nxt = 1'b1;
            code_nxt = `SDA_AB_MAP_LEN;
         end else begin
            ok_nxt = 1'b1;
            upd_nxt = 1'b1;
            len_nxt = add_len[3:0];
         end
      end
   end

   // next state
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (take_err) begin
               state_nxt = ST_PUSH;
            end else if (take_req &&
                         req_data[7:5] != `SDA_CCS_ABORT) begin
               state_nxt = ST_LOOK;
            end
         end
         ST_LOOK: begin
            if (fail_nxt) begin
               state_nxt = ST_PUSH;
            end else if (ok_nxt) begin
               state_nxt = ST_IDLE;
            end else begin
               state_nxt = ST_MAP;
            end
         end
         ST_MAP: begin
            if (fail_nxt) begin
               state_nxt = ST_PUSH;
            end else begin
               state_nxt = ST_IDLE;
            end
         end
         ST_PUSH: begin
            if (fifo_ready) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // sequencing, segment tracking and accepted request hand-off
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_r <= ST_IDLE;
         frm_r <= 64'h0000000000000000;
         code_r <= 32'h00000000;
         toggle_r <= 1'b0;
         seg_r <= 1'b0;
         acc_valid_r <= 1'b0;
         acc_data_r <= 64'h0000000000000000;
      end else begin
         state_r <= state_nxt;
         acc_valid_r <= 1'b0;
         if (take_req) begin
            frm_r <= req_data;
         end
         if (take_err) begin
            code_r <= `SDA_AB_GENERAL;
         end else if (fail_nxt) begin
            code_r <= code_nxt;
         end
         if (ok_nxt) begin
            acc_valid_r <= 1'b1;
            acc_data_r <= frm_r;
         end
         // segment window: opened by an upload of a long object
         if (take_req && req_data[7:5] == `SDA_CCS_ABORT) begin
            // master abort: code not looked at, no reply
            seg_r <= 1'b0;
            toggle_r <= 1'b0;
         end else if (take_err || fail_nxt) begin
            seg_r <= 1'b0;
            toggle_r <= 1'b0;
         end else if (ok_nxt && ccs == `SDA_CCS_UL_SEG) begin
            toggle_r <= ~toggle_r;
            if (seg_last) begin
               seg_r <= 1'b0;
            end
         end else if (ok_nxt && ccs == `SDA_CCS_UL_INIT) begin
            seg_r <= od_seg;
            toggle_r <= 1'b0;
         end else if (ok_nxt) begin
            seg_r <= 1'b0;
            toggle_r <= 1'b0;
         end else if (seg_last) begin
            seg_r <= 1'b0;
         end
      end
   end

   // per-mapping payload lengths, one slot per mapping
   integer i;
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (i = 0; i < `SDA_PDO_SLOTS; i = i + 1) begin
            map_len_r[i] <= 4'h0;
         end
      end else if (upd_nxt) begin
         map_len_r[slot] <= len_nxt;
      end
   end

   // abort reply buffer toward the bus
   sda_fifo #(
      .WIDTH(`SDA_FIFO_WIDTH),
      .DEPTH(`SDA_FIFO_DEPTH),
      .AW(`SDA_FIFO_AW)
   ) u_fifo (
      .mclk(mclk),
      .rst(rst),
      .in_valid(state_r == ST_PUSH),
      .in_ready(fifo_ready),
      // code low byte first in bytes 4..7
      .in_data({code_r, sub, idx, `SDA_ABORT_BYTE}),
      .out_valid(rsp_valid),
      .out_ready(rsp_ready),
      .out_data(rsp_data)
   );

endmodule

`default_nettype wire

// *** verif/sda_assert_monitor.sv ***
`default_nettype none
// watches abort replies, pdo status and request handling
module sda_assert_monitor (
   input wire logic mclk,
   input wire logic rst,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic [63:0] req_data,
   input wire logic [1:0] nmt_state,
   input wire logic gen_err_valid,
   input wire logic gen_err_ready,
   input wire logic acc_valid,
   input wire logic [63:0] acc_data,
   input wire logic rsp_valid,
   input wire logic rsp_ready,
   input wire logic [63:0] rsp_data,
   input wire logic pdo_active,
   input wire logic [63:0] pdo_len,
   input wire logic seg_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   logic take;
   logic pdo_w;
   logic over;
   // request taken; accepted download to a pdo parameter object
   assign take = req_valid && req_ready;
   assign pdo_w = acc_data[7:5] == 3'h1 && acc_data[15:8] < 8'h08
      && acc_data[23:16] inside {8'h14, 8'h16, 8'h18, 8'h1a};
   // flags any mapping slot holding more than eight bytes
   always_comb begin
      over = 1'b0;
      for (int s = 0; s < 16; s++) begin
         if (pdo_len[4*s+:4] > 4'h8) over = 1'b1;
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   AST_RSP_HDR: assert property (
      rsp_valid |-> rsp_data[7:0] == 8'h80)
      else $error("abort reply header wrong");
   AST_PDO_STATE: assert property (
      pdo_active == (nmt_state == 2'h1))
      else $error("pdo activity disagrees with state");
   AST_OPER_PDO: assert property (
      acc_valid && nmt_state == 2'h1 && $past(nmt_state, 2) == 2'h1
      |-> !pdo_w) else $error("pdo parameter written while operational");
   AST_MAP_LEN: assert property (!over)
      else $error("mapping longer than eight bytes");
   AST_MST_ABORT: assert property (
      take && req_data[7:5] == 3'h4
      |-> ##2 (!acc_valid && !seg_busy)[*3])
      else $error("master abort not handled silently");
   AST_BAD_CMD: assert property (
      take && req_data[7:5] == 3'h7
      |-> ##[2:60] (rsp_valid && rsp_data[63:32] == 32'h05040001))
      else $error("unknown command not aborted");
   AST_GEN_ERR: assert property (
      gen_err_valid && gen_err_ready
      |-> ##[1:60] (rsp_valid && rsp_data[63:32] == 32'h08000000))
      else $error("engine failure not aborted");
   AST_RSP_HOLD: assert property (
      rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
      else $error("abort reply dropped before taken");
   COV_SEG: cover property (acc_valid && seg_busy);
   COV_FULL: cover property (rsp_valid && !rsp_ready && !req_ready);
   COV_OPER: cover property (acc_valid && nmt_state == 2'h1);
endmodule
bind sda_checker sda_assert_monitor sda_assert_monitor_i (.mclk, .rst,
   .req_valid, .req_ready, .req_data, .nmt_state, .gen_err_valid,
   .gen_err_ready, .acc_valid, .acc_data, .rsp_valid, .rsp_ready,
   .rsp_data, .pdo_active, .pdo_len, .seg_busy);
`default_nettype wire

// *** verif/sda_od_model.sv ***
`default_nettype none
// small object dictionary answering lookups in the same cycle
module sda_od_model (
   input wire logic [15:0] od_index,
   input wire logic [7:0] od_sub,
   output logic od_idx_ok,
   output logic od_sub_ok,
   output logic od_ro,
   output logic od_seg,
   output logic od_mappable,
   output logic [2:0] od_size,
   output logic [31:0] od_min,
   output logic [31:0] od_max
);
   timeunit 1ns;
   timeprecision 1ns;
   logic pdo_obj;
   logic map_obj;
   // pdo parameter groups, a count, a string, two process values
   always_comb begin
      pdo_obj = od_index[15:8] inside {8'h14, 8'h16, 8'h18, 8'h1a}
         && od_index[7:0] < 8'h08;
      map_obj = od_index[15:8] inside {8'h16, 8'h1a};
      od_idx_ok = pdo_obj
         || od_index inside {16'h1003, 16'h1008, 16'h6040, 16'h6060};
      od_sub_ok = map_obj ? od_sub <= 8'h08 : od_sub == 8'h00;
      od_ro = od_index == 16'h1008;
      od_seg = od_ro;
      od_mappable = od_index inside {16'h6040, 16'h6060};
      od_size = od_index == 16'h6040 ? 3'h2 :
         od_index inside {16'h1003, 16'h6060} ? 3'h1 : 3'h4;
      od_min = od_index == 16'h6060 ? 32'h00000002 : 32'h00000000;
      od_max = od_index == 16'h1003 ? 32'h00000000 :
         od_index == 16'h6060 ? 32'h00000008 : 32'hffffffff;
   end
endmodule
`default_nettype wire

// *** verif/sda_checker_bench.sv ***
`default_nettype none
module sda_checker_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, rst, req_valid, req_ready, gen_err_valid, gen_err_ready;
   logic od_idx_ok, od_sub_ok, od_ro, od_seg, od_mappable, seg_last;
   logic acc_valid, rsp_valid, rsp_ready, pdo_active, seg_busy;
   logic [63:0] req_data, acc_data, rsp_data, pdo_len;
   logic [1:0] nmt_state;
   logic [15:0] od_index;
   logic [7:0] od_sub;
   logic [2:0] od_size;
   logic [31:0] od_min, od_max;
   int err_total = 0;
   int n_tests = 0;
   int cyc = 0;
   sda_checker sda_checker_i (.mclk, .rst, .req_valid, .req_ready,
      .req_data, .nmt_state, .od_index, .od_sub, .od_idx_ok, .od_sub_ok,
      .od_ro, .od_seg, .od_mappable, .od_size, .od_min, .od_max,
      .gen_err_valid, .gen_err_ready, .seg_last, .acc_valid, .acc_data,
      .rsp_valid, .rsp_ready, .rsp_data, .pdo_active, .pdo_len, .seg_busy);
   sda_od_model sda_od_model_i (.od_index, .od_sub, .od_idx_ok,
      .od_sub_ok, .od_ro, .od_seg, .od_mappable, .od_size, .od_min, .od_max);
   // compare and count
   task automatic chk(input logic [63:0] seen, input logic [63:0] want);
      n_tests++;
      if (seen !== want) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, seen, want);
      end
   endtask
   // verdict and end of run
   task automatic results;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // offer one frame and hold it until taken
   task automatic send(input logic [63:0] f);
      int n;
      n = 0;
      req_data = f;
      req_valid = 1'b1;
      @(negedge mclk);
      while (req_ready !== 1'b1 && n < 50) begin
         n++;
         @(negedge mclk);
      end
      @(posedge mclk);
      #1 req_valid = 1'b0;
   endtask
   // wait for an acceptance pulse or an abort reply
   task automatic wt(input bit acc);
      int n;
      n = 0;
      @(negedge mclk);
      while ((acc ? acc_valid : rsp_valid) !== 1'b1 && n < 20) begin
         n++;
         @(negedge mclk);
      end
   endtask
   // frame must be handed on unchanged
   task automatic ok(input logic [63:0] f);
      send(f);
      wt(1'b1);
      chk(acc_valid, 1'b1);
      chk(acc_data, f);
      @(posedge mclk);
      #1;
   endtask
   // frame must be answered by an abort with this code
   task automatic ab(input logic [63:0] f, input logic [31:0] code);
      send(f);
      wt(1'b0);
      chk(rsp_valid, 1'b1);
      chk(rsp_data, {code, f[31:8], 8'h80});
      @(posedge mclk);
      #1;
   endtask
   // outputs straight after reset
   task automatic t_reset;
      chk(rsp_valid, 1'b0);
      chk(acc_valid, 1'b0);
      chk(seg_busy, 1'b0);
      chk(pdo_len, 64'h0);
   endtask
   // every access check except the state check, in priority order
   task automatic t_codes;
      ab(64'h0000_0000_00_6040_e0, 32'h05040001);
      ab(64'h0000_0000_00_1008_21, 32'h05040001);
      ab(64'h0000_0000_00_2000_2f, 32'h06020000);
      ab(64'h0000_0000_01_1003_2f, 32'h06090011);
      ab(64'h0000_0000_00_1008_23, 32'h06010002);
      ab(64'h0000_0000_00_1003_23, 32'h06070012);
      ab(64'h0000_0000_00_6040_2f, 32'h06070013);
      ab(64'h0000_0001_00_1003_2f, 32'h06090031);
      ab(64'h0000_0001_00_6060_2f, 32'h06090032);
      ok(64'h0000_0000_00_1003_2f);
      ok(64'h0000_0008_00_6060_2f);
      ok(64'h0000_0005_00_6040_2b);
   endtask
   // mapping limits and state gating, configured in pre-operational and in stopped
   task automatic t_map;
      nmt_state = 2'h0;
      ab(64'h1003_0008_01_1600_23, 32'h06040041);
      for (int i = 1; i <= 4; i++) begin
         ok({16'h6040, 8'h00, 8'h10, i[7:0], 16'h1600, 8'h23});
      end
      chk(pdo_len[3:0], 4'h8);
      ab(64'h6040_0010_05_1600_23, 32'h06040042);
      // bit length not a whole number of bytes
      ab(64'h6040_0011_02_1600_23, 32'h08000000);
      ok(64'h6040_0010_01_1a07_23);
      chk(pdo_len[63:60], 4'h2);
      ok(64'h0000_0000_00_1600_23);
      chk(pdo_len[3:0], 4'h0);
      nmt_state = 2'h1;
      chk(pdo_active, 1'b1);
      ab(64'h6040_0010_01_1600_23, 32'h08000022);
      ab(64'h0000_0000_00_1407_23, 32'h08000022);
      ab(64'h0000_0000_00_1807_23, 32'h08000022);
      ok(64'h0000_0005_00_6040_2b);
      nmt_state = 2'h2;
      chk(pdo_active, 1'b0);
      ok(64'h6040_0010_01_1a00_23);
      nmt_state = 2'h0;
   endtask
   // segmented upload toggling, aborts from both sides
   task automatic t_toggle;
      ok(64'h0000_0000_00_1008_40);
      chk(seg_busy, 1'b1);
      ok(64'h0000_0000_00_1008_60);
      ok(64'h0000_0000_00_1008_70);
      ab(64'h0000_0000_00_1008_70, 32'h05030000);
      chk(seg_busy, 1'b0);
      ok(64'h0000_0000_00_1008_40);
      ok(64'h0000_0000_00_1008_60);
      send(64'hdead_beef_00_1008_80);
      repeat (4) @(posedge mclk);
      #1;
      chk(seg_busy, 1'b0);
      chk(rsp_valid, 1'b0);
      ok(64'h0000_0000_00_1008_40);
      seg_last = 1'b1;
      @(posedge mclk);
      #1 seg_last = 1'b0;
      ab(64'h0000_0000_00_1008_60, 32'h08000000);
      // segment request with stray low command bits
      ab(64'h0000_0000_00_1008_61, 32'h05040001);
   endtask
   // failure raised by the dictionary engine
   task automatic t_fault;
      chk(gen_err_ready, 1'b1);
      gen_err_valid = 1'b1;
      @(posedge mclk);
      #1 gen_err_valid = 1'b0;
      wt(1'b0);
      chk(rsp_valid, 1'b1);
      chk(rsp_data, 64'h08000000_00_1008_80);
      @(posedge mclk);
      #1;
   endtask
   // reply buffer filled while the bus stalls, then drained
   task automatic t_fifo;
      rsp_ready = 1'b0;
      for (int k = 0; k < 17; k++) begin
         send(64'h0000_0000_00_6040_e0);
         // let an edge pass before the next request goes up
         @(posedge mclk);
         #1;
      end
      repeat (6) @(posedge mclk);
      #1;
      chk(req_ready, 1'b0);
      chk(gen_err_ready, 1'b0);
      rsp_ready = 1'b1;
      for (int k = 0; k < 17; k++) begin
         wt(1'b0);
         chk(rsp_valid, 1'b1);
         chk(rsp_data, 64'h05040001_00_6040_80);
         @(posedge mclk);
         #1;
      end
      repeat (3) @(posedge mclk);
      #1;
      chk(rsp_valid, 1'b0);
   endtask
   // free-running clock
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // cycle ceiling against a hang
   always @(posedge mclk) begin
      cyc++;
      if (cyc > 5000) begin
         err_total++;
         results;
      end
   end
   // reset, then every scenario in turn
   initial begin
      rst = 1'b1;
      req_valid = 1'b0;
      req_data = 64'h0;
      nmt_state = 2'h0;
      gen_err_valid = 1'b0;
      seg_last = 1'b0;
      rsp_ready = 1'b1;
      repeat (8) @(posedge mclk);
      #1 rst = 1'b0;
      t_reset;
      t_codes;
      t_map;
      t_toggle;
      t_fault;
      t_fifo;
      results;
   end
endmodule
`default_nettype wire
